// [design/wsb_pkg.sv]
// Constants shared by the serial bridge host-side I/O block.
// Assumes a single 10 MHz clock and a word-aligned Wishbone register map.
package wsb_pkg;

	// ==========================================================
	// Timing
	localparam int unsigned CLK_HZ     = 10_000_000;
	localparam int unsigned CFG_BAUD   = 38400;
	// Cycles per bit; rounds down, 260 cycles gives 0.16 % error.
	localparam int unsigned BIT_CYCLES = CLK_HZ / CFG_BAUD;
	localparam int unsigned DATA_BITS  = 8;

	// ==========================================================
	// Register map (byte addresses)
	localparam int unsigned ADR_W      = 5;
	localparam logic [4:0]  ADR_CTRL   = 5'h00;
	localparam logic [4:0]  ADR_STATUS = 5'h04;
	localparam logic [4:0]  ADR_CMD_RX = 5'h08;
	localparam logic [4:0]  ADR_CMD_TX = 5'h0C;
	localparam logic [4:0]  ADR_HS     = 5'h10;

	// Control fields and reset values.
	localparam int unsigned CTRL_DCE     = 0;
	localparam int unsigned CTRL_VOICE   = 1;
	localparam int unsigned CTRL_MASTER  = 2;
	localparam logic [2:0]  CTRL_RESET   = 3'h2;

	// Status fields.
	localparam int unsigned ST_LINK     = 0;
	localparam int unsigned ST_DISC     = 1;
	localparam int unsigned ST_CMD      = 2;
	localparam int unsigned ST_TXRDY    = 3;
	localparam int unsigned ST_CTS      = 4;
	localparam int unsigned CMD_VALID   = 8;

	// ==========================================================
	// Pin vector: rxd, clear-to-send (low active), disconnect, lines
	localparam int unsigned PIN_W    = 7;
	localparam int unsigned PIN_RXD  = 0;
	localparam int unsigned PIN_CTS  = 1;
	localparam int unsigned PIN_DISC = 2;
	localparam int unsigned PIN_HS   = 3;
	localparam logic [6:0]  PIN_RESET = 7'h03;

	// Handshake lines: bit 0 ring, 1 terminal ready, 2 carrier, 3 set
	// ready. Set bits are the lines the block drives in each emulation.
	localparam int unsigned HS_W       = 4;
	localparam logic [3:0]  HS_OUT_DTE = 4'h2;
	localparam logic [3:0]  HS_OUT_DCE = 4'hD;

endpackage : wsb_pkg

// [design/stream_buffer.sv]
// Small valid/ready FIFO used on both serial data paths.
// Assumes both sides sit on the same clock.
`timescale 1ns/100ps
module stream_buffer #(
	parameter int WIDTH = 8,
	parameter int DEPTH = 2
) (
	input  wire logic             clock,    // System clock.
	input  wire logic             arst_n,   // Asynchronous reset.
	input  wire logic             inValid,  // Source offers a word.
	input  wire logic [WIDTH-1:0] inData,   // Offered word.
	output logic                  inReady,  // Room for a word.
	output logic                  outValid, // A word is held.
	output logic [WIDTH-1:0]      outData,  // Oldest word.
	input  wire logic             outReady  // Sink takes the word.
);
	localparam int AW = $clog2(DEPTH);

	if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0) begin : g_bad
		$error("stream_buffer DEPTH must be a power of two >= 2");
	end

	typedef struct packed {
		logic [DEPTH-1:0][WIDTH-1:0] mem;
		logic [AW-1:0]               wp;
		logic [AW-1:0]               rp;
		logic [AW:0]                 cnt;
	} buf_t;

	buf_t q;
	buf_t d;
	logic push;
	logic pop;

	// ==========================================================
	// Handshake
	assign inReady  = q.cnt != (AW+1)'(DEPTH);
	assign outValid = q.cnt != '0;
	assign outData  = q.mem[q.rp];
	assign push     = inValid & inReady;
	assign pop      = outValid & outReady;

	// Pointers wrap on their own because the depth is a power of two.
	always_comb begin
		d = q;
		if (push) begin
			d.mem[q.wp] = inData;
			d.wp        = q.wp + 1'b1;
		end
		if (pop) begin
			d.rp = q.rp + 1'b1;
		end
		if (push && !pop) begin
			d.cnt = q.cnt + 1'b1;
		end else if (pop && !push) begin
			d.cnt = q.cnt - 1'b1;
		end
	end

	// State register.
	always_ff @(posedge clock or negedge arst_n) begin
		if (!arst_n) begin
			q <= '0;
		end else begin
			q <= d;
		end
	end

endmodule : stream_buffer

// [design/uart_engine.sv]
// Eight-bit, no parity, one stop bit serial transmitter and receiver.
// Assumes rxBit is already synchronised and filtered.
`timescale 1ns/100ps
module uart_engine
	import wsb_pkg::*;
#(
	parameter int BITC = wsb_pkg::BIT_CYCLES
) (
	input  wire logic       clock,   // System clock.
	input  wire logic       arst_n,  // Asynchronous reset.
	input  wire logic       rxBit,   // Filtered receive line.
	output logic [7:0]      rxData,  // Received byte.
	output logic            rxValid, // One-cycle pulse per good byte.
	input  wire logic [7:0] txData,  // Byte to send.
	input  wire logic       txValid, // Byte offered.
	output logic            txReady, // Transmitter idle.
	output logic            txd      // Transmit line, idle high.
);
	localparam int CW = $clog2(BITC + 1);
	localparam logic [CW-1:0] FULL = CW'(BITC - 1);
	localparam logic [CW-1:0] HALF = CW'(BITC / 2 - 1);

	if (BITC < 4) begin : g_bad
		$error("uart_engine needs at least four cycles per bit");
	end

	typedef enum logic [1:0] {RX_IDLE, RX_START, RX_DATA, RX_STOP} rx_t;

	typedef struct packed {
		rx_t           rxSt;
		logic [CW-1:0] rxCnt;
		logic [2:0]    rxN;
		logic [7:0]    rxSh;
		logic [7:0]    rxData;
		logic          rxValid;
		logic          txBusy;
		logic [CW-1:0] txCnt;
		logic [3:0]    txN;
		logic [9:0]    txSh;
		logic          txd;
	} uart_t;

	uart_t q;
	uart_t d;

	assign rxData  = q.rxData;
	assign rxValid = q.rxValid;
	assign txReady = !q.txBusy;
	assign txd     = q.txd;

	// ==========================================================
	// Receiver samples mid-bit; a low stop bit drops the byte.
	always_comb begin
		d         = q;
		d.rxValid = 1'b0;
		unique case (q.rxSt)
			RX_IDLE: begin
				if (!rxBit) begin
					d.rxSt  = RX_START;
					d.rxCnt = HALF;
				end
			end
			RX_START: begin
				if (q.rxCnt != '0) begin
					d.rxCnt = q.rxCnt - 1'b1;
				end else if (!rxBit) begin
					d.rxSt  = RX_DATA;
					d.rxCnt = FULL;
					d.rxN   = 3'h0;
				end else begin
					d.rxSt = RX_IDLE;
				end
			end
			RX_DATA: begin
				if (q.rxCnt != '0) begin
					d.rxCnt = q.rxCnt - 1'b1;
				end else begin
					d.rxSh  = {rxBit, q.rxSh[7:1]};
					d.rxCnt = FULL;
					d.rxN   = q.rxN + 1'b1;
					if (q.rxN == 3'h7) begin
						d.rxSt = RX_STOP;
					end
				end
			end
			RX_STOP: begin
				if (q.rxCnt != '0) begin
					d.rxCnt = q.rxCnt - 1'b1;
				end else begin
					d.rxValid = rxBit;
					d.rxData  = q.rxSh;
					d.rxSt    = RX_IDLE;
				end
			end
		endcase

		// Transmitter: start bit, data LSB first, stop bit.
		if (!q.txBusy) begin
			if (txValid) begin
				d.txBusy = 1'b1;
				d.txSh   = {1'b1, txData, 1'b0};
				d.txd    = 1'b0;
				d.txN    = 4'h0;
				d.txCnt  = FULL;
			end
		end else if (q.txCnt != '0) begin
			d.txCnt = q.txCnt - 1'b1;
		end else if (q.txN == 4'h9) begin
			d.txBusy = 1'b0;
			d.txd    = 1'b1;
		end else begin
			d.txSh  = {1'b1, q.txSh[9:1]};
			d.txd   = q.txSh[1];
			d.txN   = q.txN + 1'b1;
			d.txCnt = FULL;
		end
	end

	// State register; line idles high.
	always_ff @(posedge clock or negedge arst_n) begin
		if (!arst_n) begin
			q      <= '0;
			q.txd  <= 1'b1;
		end else begin
			q <= d;
		end
	end

endmodule : uart_engine

// [design/wireless_serial_bridge_io.sv]
// Host-facing I/O of the radio serial cable replacement unit.
// Assumes the radio stack sits on the same clock and reports the link.
`timescale 1ns/100ps
module wireless_serial_bridge_io
	import wsb_pkg::*;
#(
	parameter int VW    = 16,
	parameter int DEPTH = 2
) (
	input  wire logic              clock,        // 10 MHz clock.
	input  wire logic              arst_n,       // Async reset.
	input  wire logic              wb_cyc_i,     // Bus cycle.
	input  wire logic              wb_stb_i,     // Bus strobe.
	input  wire logic              wb_we_i,      // Write enable.
	input  wire logic [wsb_pkg::ADR_W-1:0] wb_adr_i, // Byte address.
	input  wire logic [3:0]        wb_sel_i,     // Byte selects.
	input  wire logic [31:0]       wb_dat_i,     // Write data.
	output logic [31:0]            wb_dat_o,     // Read data.
	output logic                   wb_ack_o,     // Acknowledge.
	output logic                   txd,          // Serial out.
	input  wire logic              rxd,          // Serial in.
	output logic                   rtsN,         // Request to send.
	input  wire logic              ctsN,         // Clear to send.
	input  wire logic              discReq,      // Disconnect request.
	output logic                   linkUp,       // Link indicator.
	input  wire logic [3:0]        hsIn,         // Line pins in.
	output logic [3:0]             hsOut,        // Line pins out.
	output logic [3:0]             hsOe,         // Line drive enables.
	input  wire logic              radioUp,      // Stack has a link.
	output logic                   connAllow,    // Stack may link.
	output logic                   radioMaster,  // Master role.
	output logic [7:0]             radioTxData,  // Data to radio.
	output logic                   radioTxValid, // Data valid.
	input  wire logic              radioTxReady, // Radio takes it.
	input  wire logic [7:0]        radioRxData,  // Data from radio.
	input  wire logic              radioRxValid, // Data valid.
	output logic                   radioRxReady, // Block takes it.
	input  wire logic [3:0]        remoteHs,     // Remote line levels.
	output logic [3:0]             hsToRadio,    // Local line levels.
	input  wire logic [VW-1:0]     micSample,    // Voice in sample.
	input  wire logic              micStb,       // Sample strobe.
	output logic [VW-1:0]          voiceTx,      // Voice to radio.
	output logic                   voiceTxStb,   // Voice strobe.
	input  wire logic [VW-1:0]     radioVoice,   // Voice from radio.
	input  wire logic              radioVoiceStb,// Voice strobe.
	output logic [VW-1:0]          spkSample,    // Voice out sample.
	output logic                   spkStb        // Voice out strobe.
);
	if (VW < 1 || VW > 32) begin : g_bad
		$error("VW must lie between 1 and 32");
	end

	typedef struct packed {
		logic [PIN_W-1:0] s1;
		logic [PIN_W-1:0] s2;
		logic [PIN_W-1:0] s3;
		logic [PIN_W-1:0] pins;
		logic             ack;
		logic [31:0]      rdat;
		logic             dce;
		logic             voiceEn;
		logic             master;
		logic [7:0]       cmdByte;
		logic             cmdValid;
		logic [7:0]       swByte;
		logic             swValid;
		logic             linkUp;
		logic             connAllow;
		logic             rtsN;
		logic [3:0]       hsOut;
		logic [3:0]       hsOe;
		logic [3:0]       hsToRadio;
		logic [VW-1:0]    voiceTx;
		logic             voiceTxStb;
		logic [VW-1:0]    spk;
		logic             spkStb;
	} state_t;

	state_t q;
	state_t d;

	logic [7:0] urxData;
	logic       urxValid;
	logic       rxInReady;
	logic [7:0] rxOutData;
	logic       rxOutValid;
	logic       rxOutReady;
	logic [7:0] txInData;
	logic       txInValid;
	logic       txInReady;
	logic [7:0] txOutData;
	logic       txOutValid;
	logic       txOutReady;
	logic       utxReady;
	logic       swPush;
	logic       busReq;
	logic       ctsF;

	// ==========================================================
	// Serial engine, fixed 38400 baud 8N1.
	uart_engine #(
		.BITC (BIT_CYCLES)
	) u_uart (
		.clock   (clock),
		.arst_n  (arst_n),
		.rxBit   (q.pins[PIN_RXD]),
		.rxData  (urxData),
		.rxValid (urxValid),
		.txData  (txOutData),
		.txValid (txOutValid & ctsF),
		.txReady (utxReady),
		.txd     (txd)
	);

	// Host to radio or to the command holder. A byte the host sends after
	// RTS has risen still fits, because RTS rises as soon as one is held.
	stream_buffer #(
		.WIDTH (8),
		.DEPTH (DEPTH)
	) u_rxbuf (
		.clock    (clock),
		.arst_n   (arst_n),
		.inValid  (urxValid),
		.inData   (urxData),
		.inReady  (rxInReady),
		.outValid (rxOutValid),
		.outData  (rxOutData),
		.outReady (rxOutReady)
	);

	// Radio or software replies to the host.
	stream_buffer #(
		.WIDTH (8),
		.DEPTH (DEPTH)
	) u_txbuf (
		.clock    (clock),
		.arst_n   (arst_n),
		.inValid  (txInValid),
		.inData   (txInData),
		.inReady  (txInReady),
		.outValid (txOutValid),
		.outData  (txOutData),
		.outReady (txOutReady)
	);

	// ==========================================================
	// Data routing: linked traffic goes to the radio untouched, otherwise
	// bytes are commands for software.
	assign ctsF         = !q.pins[PIN_CTS];
	assign txOutReady   = utxReady & ctsF;
	assign rxOutReady   = q.linkUp ? radioTxReady : !q.cmdValid;
	assign radioTxValid = rxOutValid & q.linkUp;
	assign radioTxData  = rxOutData;
	assign radioRxReady = txInReady & q.linkUp;
	assign swPush       = q.swValid & !q.linkUp & txInReady;
	assign txInValid    = q.linkUp ? radioRxValid : q.swValid;
	assign txInData     = q.linkUp ? radioRxData : q.swByte;
	assign busReq       = wb_cyc_i & wb_stb_i & !q.ack;

	// Outputs straight from the state register.
	assign wb_dat_o    = q.rdat;
	assign wb_ack_o    = q.ack;
	assign rtsN        = q.rtsN;
	assign linkUp      = q.linkUp;
	assign hsOut       = q.hsOut;
	assign hsOe        = q.hsOe;
	assign connAllow   = q.connAllow;
	assign radioMaster = q.master;
	assign hsToRadio   = q.hsToRadio;
	assign voiceTx     = q.voiceTx;
	assign voiceTxStb  = q.voiceTxStb;
	assign spkSample   = q.spk;
	assign spkStb      = q.spkStb;

	// ==========================================================
	// Next state.
	always_comb begin
		logic [PIN_W-1:0] agree;
		logic [3:0]       drive;
		logic             disc;
		agree = '0;
		drive = '0;
		disc  = 1'b0;
		d     = q;

		// Three-stage synchroniser; a level counts once stages 2 and 3
		// agree, which also rejects a single-cycle glitch.
		d.s1   = {hsIn, discReq, ctsN, rxd};
		d.s2   = q.s1;
		d.s3   = q.s2;
		agree  = ~(q.s2 ^ q.s3);
		d.pins = (q.s3 & agree) | (q.pins & ~agree);
		disc   = q.pins[PIN_DISC];

		// Link state; the indicator falls with the stack or the request.
		d.connAllow = !disc;
		d.linkUp    = radioUp & !disc;

		// Handshake emulation, carried apart from the data stream.
		drive       = q.dce ? HS_OUT_DCE : HS_OUT_DTE;
		d.hsOe      = drive;
		d.hsOut     = q.linkUp ? (remoteHs & drive) : 4'h0;
		d.hsToRadio = q.pins[PIN_HS +: HS_W] & ~drive;

		// Voice passes only while linked and enabled.
		d.voiceTxStb = micStb & q.linkUp & q.voiceEn;
		if (micStb) begin
			d.voiceTx = micSample;
		end
		d.spkStb = radioVoiceStb & q.linkUp & q.voiceEn;
		if (radioVoiceStb) begin
			d.spk = radioVoice;
		end

		// Flow control toward the host: stop it once a byte is held.
		d.rtsN = rxOutValid | !rxInReady;

		// Software reply leaves once the reply path takes it.
		if (swPush) begin
			d.swValid = 1'b0;
		end

		// Bus slave: one wait state, then ack for one cycle.
		d.ack  = busReq;
		d.rdat = 32'h0;
		if (busReq && !wb_we_i) begin
			unique case (wb_adr_i)
				ADR_CTRL: begin
					d.rdat[CTRL_DCE]    = q.dce;
					d.rdat[CTRL_VOICE]  = q.voiceEn;
					d.rdat[CTRL_MASTER] = q.master;
				end
				ADR_STATUS: begin
					d.rdat[ST_LINK]  = q.linkUp;
					d.rdat[ST_DISC]  = disc;
					d.rdat[ST_CMD]   = q.cmdValid;
					d.rdat[ST_TXRDY] = !q.swValid;
					d.rdat[ST_CTS]   = ctsF;
				end
				ADR_CMD_RX: begin
					d.rdat[7:0]       = q.cmdByte;
					d.rdat[CMD_VALID] = q.cmdValid;
					d.cmdValid        = 1'b0;
				end
				ADR_HS: begin
					d.rdat[3:0] = q.pins[PIN_HS +: HS_W];
					d.rdat[7:4] = remoteHs;
				end
				default: begin
					d.rdat = 32'h0;
				end
			endcase
		end
		if (busReq && wb_we_i && wb_sel_i[0]) begin
			unique case (wb_adr_i)
				ADR_CTRL: begin
					d.dce     = wb_dat_i[CTRL_DCE];
					d.voiceEn = wb_dat_i[CTRL_VOICE];
					d.master  = wb_dat_i[CTRL_MASTER];
				end
				ADR_CMD_TX: begin
					if (!q.swValid && !q.linkUp) begin
						d.swByte  = wb_dat_i[7:0];
						d.swValid = 1'b1;
					end
				end
				default: begin
					d.swValid = d.swValid;
				end
			endcase
		end

		// Command capture comes last so a new byte wins over the pop.
		if (rxOutValid && rxOutReady && !q.linkUp) begin
			d.cmdByte  = rxOutData;
			d.cmdValid = 1'b1;
		end
	end

	// State register.
	always_ff @(posedge clock or negedge arst_n) begin
		if (!arst_n) begin
			q         <= '0;
			q.s1      <= PIN_RESET;
			q.s2      <= PIN_RESET;
			q.s3      <= PIN_RESET;
			q.pins    <= PIN_RESET;
			q.dce     <= CTRL_RESET[CTRL_DCE];
			q.voiceEn <= CTRL_RESET[CTRL_VOICE];
			q.master  <= CTRL_RESET[CTRL_MASTER];
			q.rtsN    <= 1'b1;
			q.hsOe    <= HS_OUT_DTE;
		end else begin
			q <= d;
		end
	end

endmodule : wireless_serial_bridge_io

// [verif/wsb_bridge_sva.sv]
// Checker for the serial bridge host-side I/O block.
// Assumes it is bound to the top module and sees only its ports.
`timescale 1ns/100ps
module wsb_bridge_sva #(
	parameter int VW = 16
) (
	input wire logic          clock,         // Clock.
	input wire logic          arst_n,        // Reset, low active.
	input wire logic          wb_cyc_i,      // Bus cycle.
	input wire logic          wb_stb_i,      // Bus strobe.
	input wire logic [31:0]   wb_dat_o,      // Read data.
	input wire logic          wb_ack_o,      // Acknowledge.
	input wire logic          discReq,       // Disconnect request.
	input wire logic          linkUp,        // Link indicator.
	input wire logic          connAllow,     // Stack may link.
	input wire logic          radioUp,       // Stack has a link.
	input wire logic          radioTxValid,  // Data to radio valid.
	input wire logic [3:0]    hsOe,          // Line enables.
	input wire logic [3:0]    hsOut,         // Line outputs.
	input wire logic [3:0]    remoteHs,      // Remote levels.
	input wire logic [VW-1:0] micSample,     // Voice in.
	input wire logic          micStb,        // Voice in strobe.
	input wire logic [VW-1:0] voiceTx,       // Voice to radio.
	input wire logic          voiceTxStb,    // Its strobe.
	input wire logic [VW-1:0] radioVoice,    // Voice from radio.
	input wire logic          radioVoiceStb, // Its strobe.
	input wire logic [VW-1:0] spkSample,     // Voice out.
	input wire logic          spkStb         // Its strobe.
);
	import wsb_pkg::*;
	// ==========================================================
	// Bus and link properties.
	default clocking cb @(posedge clock); endclocking
	default disable iff (!arst_n);
	chk_ack_pulse: assert property (wb_ack_o |=> !wb_ack_o)
		else $error("ack longer than one cycle");
	chk_ack_answer: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o
		|=> wb_ack_o) else $error("request not answered");
	chk_dat_idle: assert property (!wb_ack_o |-> wb_dat_o == 32'h0)
		else $error("read data outside ack");
	chk_link_radio: assert property (
		!radioUp |=> !linkUp)
		else $error("link shown without radio link");
	chk_disc_link: assert property (
		discReq [*6] |-> !linkUp && !connAllow)
		else $error("disconnect not honoured");
	// The radio must have reported a link one cycle before data leaves.
	chk_data_gate: assert property (
		radioTxValid |-> linkUp && $past(radioUp))
		else $error("data offered to radio while unlinked");
	// ==========================================================
	// Handshake lines and voice; a switch of emulation mode must
	// never drive lines other than the two emulation sets.
	chk_line_dir: assert property (
		hsOe == HS_OUT_DTE || hsOe == HS_OUT_DCE)
		else $error("line drive set not DTE or DCE");
	chk_line_pass: assert property (
		linkUp && $past(linkUp) && $stable(remoteHs)
		&& $stable(hsOe) |-> hsOut == (remoteHs & hsOe))
		else $error("remote line level not passed");
	chk_voice_out: assert property (
		voiceTxStb |-> $past(micStb)
		&& voiceTx == $past(micSample))
		else $error("voice to radio altered");
	chk_voice_in: assert property (
		spkStb |-> $past(radioVoiceStb)
		&& spkSample == $past(radioVoice))
		else $error("voice from radio altered");
endmodule : wsb_bridge_sva
bind wireless_serial_bridge_io wsb_bridge_sva #(.VW(VW)) chk_u (.*);

// [verif/host_uart_model.sv]
// Host serial equipment model: 8N1 at the fixed configuration rate.
// Assumes the clock of the block and bit times counted in its cycles.
`timescale 1ns/100ps
module host_uart_model (
	input  wire logic clock, // Clock.
	input  wire logic txd,   // Block serial out.
	input  wire logic rtsN,  // Block takes a byte while low.
	output logic      rxd    // Block serial in.
);
	import wsb_pkg::*;
	logic [7:0] got[$];
	logic [7:0] v;
	initial rxd = 1'b1;
	// ==========================================================
	// Sender: start bit, eight bits LSB first, one stop bit.
	task automatic send(input logic [7:0] b);
		// Flow control: a byte starts only while the block asks for one.
		do @(posedge clock); while (rtsN !== 1'b0);
		rxd <= 1'b0;
		repeat (BIT_CYCLES) @(posedge clock);
		for (int i = 0; i < 8; i++) begin
			rxd <= b[i];
			repeat (BIT_CYCLES) @(posedge clock);
		end
		rxd <= 1'b1;
		repeat (BIT_CYCLES) @(posedge clock);
	endtask : send
	// Receiver samples each bit in its middle, where the line is settled.
	always begin
		@(negedge txd);
		repeat (BIT_CYCLES / 2) @(posedge clock);
		for (int i = 0; i < 8; i++) begin
			repeat (BIT_CYCLES) @(posedge clock);
			v[i] = txd;
		end
		repeat (BIT_CYCLES) @(posedge clock);
		got.push_back(v);
	end
endmodule : host_uart_model

// [verif/wireless_serial_bridge_io_tb_top.sv]
// Self-checking bench for the serial bridge host-side I/O block.
// Assumes the host model for serial traffic; radio ports driven here.
`timescale 1ns/100ps
module wireless_serial_bridge_io_tb_top;
	import wsb_pkg::*;
	logic clock, arst_n, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o, txd, rxd;
	logic rtsN, ctsN, discReq, linkUp, radioUp, connAllow, radioMaster;
	logic radioTxValid, radioTxReady, radioRxValid, radioRxReady;
	logic micStb, voiceTxStb, radioVoiceStb, spkStb;
	logic [4:0]  wb_adr_i;
	logic [3:0]  wb_sel_i, hsIn, hsOut, hsOe, remoteHs, hsToRadio;
	logic [31:0] wb_dat_i, wb_dat_o, q;
	logic [7:0]  radioTxData, radioRxData;
	logic [15:0] micSample, voiceTx, radioVoice, spkSample;
	int failures, samples_checked, n;
	wireless_serial_bridge_io dut_u (.*);
	host_uart_model host_u (.clock(clock), .txd(txd), .rtsN(rtsN), .rxd(rxd));
	// ==========================================================
	// Shared tasks.
	task automatic give_verdict;
		if (failures == 0 && samples_checked > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask : give_verdict
	task automatic cmp(input logic [31:0] g, input logic [31:0] e);
		samples_checked++;
		if (g !== e) begin
			failures++;
			$display("BAD %0t got %h exp %h", $time, g, e);
		end
	endtask : cmp
	// One classic cycle; holds the request until ack, then releases it.
	// Only the watchdog ends a wait for an answer that never comes.
	task automatic bus(input logic w, input logic [4:0] a,
		input logic [31:0] d);
		@(posedge clock);
		wb_cyc_i <= 1'b1;
		wb_stb_i <= 1'b1;
		wb_we_i  <= w;
		wb_adr_i <= a;
		wb_dat_i <= d;
		wb_sel_i <= 4'hF;
		do @(posedge clock); while (wb_ack_o !== 1'b1);
		q = wb_dat_o;
		wb_cyc_i <= 1'b0;
		wb_stb_i <= 1'b0;
	endtask : bus
	task automatic wait_rx(input int c);
		int k;
		k = 0;
		while (host_u.got.size() < c && k < 40000) begin
			@(posedge clock);
			k++;
		end
		cmp(host_u.got.size(), c);
	endtask : wait_rx
	// ==========================================================
	// Clock and watchdog; the run needs about 18300 cycles.
	initial begin
		clock = 1'b0;
		forever #50 clock = ~clock;
	end
	initial begin
		#6_000_000;
		failures++;
		give_verdict();
	end
	// ==========================================================
	// Main sequence.
	initial begin
		{wb_cyc_i, wb_stb_i, wb_we_i, discReq, radioUp, radioTxReady} = '0;
		{radioRxValid, micStb, radioVoiceStb, ctsN} = '0;
		{wb_adr_i, wb_sel_i, wb_dat_i, hsIn, remoteHs, radioRxData} = '0;
		{micSample, radioVoice} = '0;
		arst_n = 1'b0;
		repeat (3) @(posedge clock);
		arst_n <= 1'b1;
		@(posedge clock);
		cmp(linkUp, 1'b0);
		cmp(hsOe, HS_OUT_DTE);
		bus(1'b0, ADR_CTRL, 0);
		cmp(q, CTRL_RESET);
		bus(1'b0, 5'h14, 0);
		cmp(q, 0);
		// Unlinked: a host byte is a command and a reply goes back.
		host_u.send(8'hA5);
		repeat (10) @(posedge clock);
		bus(1'b0, ADR_STATUS, 0);
		cmp(q[ST_CMD], 1'b1);
		bus(1'b0, ADR_CMD_RX, 0);
		cmp(q[8:0], 9'h1A5);
		bus(1'b1, ADR_CMD_TX, 32'h3C);
		wait_rx(1);
		cmp(host_u.got.pop_front(), 8'h3C);
		// Linked: host byte goes to the radio, not to commands.
		radioUp <= 1'b1;
		repeat (3) @(posedge clock);
		cmp(linkUp, 1'b1);
		host_u.send(8'h5A);
		n = 0;
		while (radioTxValid !== 1'b1 && n++ < 100) @(posedge clock);
		cmp(radioTxValid, 1'b1);
		cmp(radioTxData, 8'h5A);
		cmp(rtsN, 1'b1);
		radioTxReady <= 1'b1;
		@(posedge clock);
		radioTxReady <= 1'b0;
		// A reply written while linked is refused and leaves the slot free.
		bus(1'b1, ADR_CMD_TX, 32'h55);
		bus(1'b0, ADR_STATUS, 0);
		cmp(q[ST_CMD], 1'b0);
		cmp(q[ST_TXRDY], 1'b1);
		cmp(rtsN, 1'b0);
		// Host stalls; radio fills the buffer until it is refused.
		ctsN <= 1'b1;
		n = 0;
		for (int i = 0; i < 6; i++) begin
			radioRxValid <= 1'b1;
			radioRxData  <= 8'(8'h90 + i);
			@(posedge clock);
			if (radioRxReady !== 1'b1) break;
			n++;
		end
		radioRxValid <= 1'b0;
		cmp(n >= 2 && n < 6, 1'b1);
		// Long enough for a second byte to arrive had the stall leaked;
		// only the byte already in flight may reach the host.
		repeat (5400) @(posedge clock);
		cmp(host_u.got.size(), 1);
		ctsN <= 1'b0;
		wait_rx(n);
		for (int j = 0; j < n; j++)
			cmp(host_u.got.pop_front(), 8'(8'h90 + j));
		// Handshake lines in both emulations; master role on.
		hsIn     <= 4'hF;
		remoteHs <= 4'hA;
		repeat (8) @(posedge clock);
		cmp(hsToRadio, 4'hF & ~HS_OUT_DTE);
		cmp(hsOut, 4'hA & HS_OUT_DTE);
		bus(1'b0, ADR_HS, 0);
		cmp(q[7:0], 8'hAF);
		bus(1'b1, ADR_CTRL, 32'h7);
		repeat (8) @(posedge clock);
		cmp(hsOe, HS_OUT_DCE);
		cmp(hsToRadio, 4'hF & ~HS_OUT_DCE);
		cmp(hsOut, 4'hA & HS_OUT_DCE);
		cmp(radioMaster, 1'b1);
		// Voice both ways at once.
		micSample     <= 16'h1234;
		radioVoice    <= 16'hBEEF;
		micStb        <= 1'b1;
		radioVoiceStb <= 1'b1;
		@(posedge clock);
		micStb        <= 1'b0;
		radioVoiceStb <= 1'b0;
		@(posedge clock);
		cmp(voiceTxStb, 1'b1);
		cmp(voiceTx, 16'h1234);
		cmp(spkStb, 1'b1);
		cmp(spkSample, 16'hBEEF);
		// Voice switched off: the strobe toward the radio stays low for a mic sample.
		bus(1'b1, ADR_CTRL, 32'h5);
		micStb <= 1'b1;
		@(posedge clock);
		micStb <= 1'b0;
		@(posedge clock);
		cmp(voiceTxStb, 1'b0);
		// Disconnect request drops the link while the radio still has it.
		discReq <= 1'b1;
		repeat (8) @(posedge clock);
		cmp(linkUp, 1'b0);
		cmp(connAllow, 1'b0);
		cmp(hsOut, 4'h0);
		bus(1'b0, ADR_STATUS, 0);
		cmp(q[ST_DISC], 1'b1);
		// Request withdrawn: the link returns, then radio loss drops it.
		discReq <= 1'b0;
		repeat (8) @(posedge clock);
		cmp(linkUp, 1'b1);
		cmp(connAllow, 1'b1);
		radioUp <= 1'b0;
		repeat (2) @(posedge clock);
		cmp(linkUp, 1'b0);
		give_verdict();
	end
endmodule : wireless_serial_bridge_io_tb_top
